// >>> rtl/btr_pkg.sv
// Constants and carrier types for the bus target region window block.
// Assumes a 32-bit AXI4-Lite register bus and one 25 MHz clock.
package btr_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [31:0] BTR_REGION_OFF = 32'h0000_0000; // Region n at 4*n
	localparam logic [31:0] BTR_STATUS_OFF = 32'h0000_0100;
	localparam logic [31:0] BTR_REGION_RST = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Region window fields
	// ----------------------------------------------------------------
	localparam int BTR_BASE_LSB = 10;
	localparam int BTR_BASE_W = 22;
	localparam int BTR_PRIORITY_LEVEL_BIT = 9;
	localparam int BTR_SIZE_LSB = 3;
	localparam int BTR_SIZE_W = 5;
	localparam int BTR_UNIT_LOG2 = 10; // 1024-byte granule
	localparam int BTR_SPAN_W = 42; // Holds base plus the largest length
	localparam logic [31:0] BTR_IMPL_MASK = 32'hffff_fef8;
	localparam int BTR_STAT_HIT_LSB = 16;

	// ----------------------------------------------------------------
	// Bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] BTR_RESP_OKAY = 2'h0;
	localparam logic [1:0] BTR_RESP_SLVERR = 2'h2;

	// AXI4-Lite requests toward the slave
	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} btr_axi_req_t;

	// AXI4-Lite answers from the slave
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} btr_axi_rsp_t;

endpackage : btr_pkg

// >>> rtl/btr_region_window.sv
// Region window registers of one bus target, with the address check.
// Assumes an AXI4-Lite master and a checker on the same aclk domain.
//
// Contract
// - Bits 31:10 hold the 22-bit region base address.
// - Bit 9 set means priority level 2, clear means level 1.
// - Size field 7:3 gives length 2^(size-1) times 1024 bytes.
// - Size zero marks the region absent; no checks apply then.
// - Bit 8 and bits 2:0 and other unused bits read zero.
// - Chosen bits of some regions are read-only preset values.
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
module btr_region_window #(
	parameter int NREG = 8,
	parameter logic [NREG-1:0][31:0] RO_MASK = '0,
	parameter logic [NREG-1:0][31:0] PRESET = '0
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire btr_pkg::btr_axi_req_t axi_req,
	output btr_pkg::btr_axi_rsp_t axi_rsp,
	// Access check from the initiator side
	input wire logic chk_valid,
	input wire logic [31:0] chk_addr,
	output logic [NREG-1:0] chk_hit,
	output logic chk_any,
	output logic chk_prio
);
	import btr_pkg::*;

	localparam int IW = (NREG > 1) ? $clog2(NREG) : 1;

	typedef struct packed {
		logic [NREG-1:0][31:0] regs;
		logic aw_have;
		logic [31:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [NREG-1:0] hit;
		logic any;
		logic prio;
	} btr_state_t;

	btr_state_t q;
	btr_state_t d;
	btr_state_t rst_s;
	logic [NREG-1:0] present_w;
	logic [NREG-1:0] prio_w;
	logic [NREG-1:0] hit_w;
	logic [NREG-1:0] ro_ok_w;
	logic [NREG-1:0][BTR_SPAN_W-1:0] base_w;
	logic [NREG-1:0][BTR_SPAN_W-1:0] end_w;
	logic [31:0] status_w;
	logic wr_commit;
	logic wr_reg;
	logic [IW-1:0] wr_idx;
	logic [31:0] wr_new;
	logic rd_region;

	// ----------------------------------------------------------------
	// Per-region decode
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NREG; i++) begin : g_region
		logic [BTR_SIZE_W-1:0] size;
		logic [BTR_SPAN_W-1:0] len;
		logic [BTR_SPAN_W-1:0] addr_x;
		assign size = q.regs[i][BTR_SIZE_LSB +: BTR_SIZE_W];
		assign present_w[i] = (size != '0);
		assign prio_w[i] = q.regs[i][BTR_PRIORITY_LEVEL_BIT];
		assign base_w[i] = {10'h000, q.regs[i][BTR_BASE_LSB +: BTR_BASE_W], 10'h000};
		// length decode; the shift only runs for a present region
		assign len = present_w[i] ?
			(BTR_SPAN_W'(1) << (BTR_SPAN_W'(size) - BTR_SPAN_W'(1) + BTR_SPAN_W'(BTR_UNIT_LOG2)))
			: '0;
		assign end_w[i] = base_w[i] + len;
		assign addr_x = {10'h000, chk_addr};
		assign hit_w[i] = present_w[i] && (addr_x >= base_w[i]) && (addr_x < end_w[i]);
		assign ro_ok_w[i] = ((q.regs[i] ^ PRESET[i]) & RO_MASK[i] & BTR_IMPL_MASK) == '0;
		// Reset image keeps preset bits in place
		assign rst_s.regs[i] = BTR_REGION_RST | (PRESET[i] & RO_MASK[i] & BTR_IMPL_MASK);
	end

	// Status shows which regions are present and the check result of the previous cycle, zero if no check then
	assign status_w = {16'(q.hit), 16'(present_w)};

	// Reset image of the control fields; the bus is ready at once
	assign rst_s.aw_have = 1'b0;
	assign rst_s.aw_addr = '0;
	assign rst_s.w_have = 1'b0;
	assign rst_s.w_data = '0;
	assign rst_s.w_strb = '0;
	assign rst_s.awready = 1'b1;
	assign rst_s.wready = 1'b1;
	assign rst_s.bvalid = 1'b0;
	assign rst_s.bresp = BTR_RESP_OKAY;
	assign rst_s.arready = 1'b1;
	assign rst_s.rvalid = 1'b0;
	assign rst_s.rdata = '0;
	assign rst_s.rresp = BTR_RESP_OKAY;
	assign rst_s.hit = '0;
	assign rst_s.any = 1'b0;
	assign rst_s.prio = 1'b0;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		wr_commit = 1'b0;
		wr_reg = 1'b0;
		wr_idx = '0;
		wr_new = '0;
		rd_region = 1'b0;
		// Address and data are caught separately, in either order
		if (q.awready && axi_req.awvalid) begin
			d.aw_have = 1'b1;
			d.aw_addr = axi_req.awaddr;
		end
		if (q.wready && axi_req.wvalid) begin
			d.w_have = 1'b1;
			d.w_data = axi_req.wdata;
			d.w_strb = axi_req.wstrb;
		end
		if (q.bvalid && axi_req.bready) begin
			d.bvalid = 1'b0;
		end
		// Commit waits for a free response slot so no answer is lost
		if (d.aw_have && d.w_have && !q.bvalid) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = BTR_RESP_SLVERR;
			wr_commit = 1'b1;
			if (d.aw_addr[31:2] < 30'(NREG)) begin
				wr_reg = 1'b1;
				wr_idx = IW'(d.aw_addr[31:2]);
				wr_new = q.regs[wr_idx];
				for (int b = 0; b < 4; b++) begin
					if (d.w_strb[b]) begin
						wr_new[b*8 +: 8] = d.w_data[b*8 +: 8];
					end
				end
				wr_new = (q.regs[wr_idx] & ~(BTR_IMPL_MASK & ~RO_MASK[wr_idx]))
					| (wr_new & BTR_IMPL_MASK & ~RO_MASK[wr_idx]);
				d.regs[wr_idx] = wr_new;
				d.bresp = BTR_RESP_OKAY;
			end else if (d.aw_addr == BTR_STATUS_OFF) begin
				d.bresp = BTR_RESP_OKAY; // Status is read-only; write dropped
			end
		end
		d.awready = !d.aw_have && !d.bvalid;
		d.wready = !d.w_have && !d.bvalid;
		// Read channel: one read in flight
		if (q.rvalid && axi_req.rready) begin
			d.rvalid = 1'b0;
		end
		if (q.arready && axi_req.arvalid) begin
			d.rvalid = 1'b1;
			d.rresp = BTR_RESP_OKAY;
			if (axi_req.araddr[31:2] < 30'(NREG)) begin
				rd_region = 1'b1;
				d.rdata = q.regs[IW'(axi_req.araddr[31:2])] & BTR_IMPL_MASK;
			end else if (axi_req.araddr == BTR_STATUS_OFF) begin
				d.rdata = status_w;
			end else begin
				d.rdata = '0;
				d.rresp = BTR_RESP_SLVERR;
			end
		end
		d.arready = !d.rvalid;
		d.hit = chk_valid ? hit_w : '0;
		d.any = chk_valid && (|hit_w);
		d.prio = chk_valid && (|(hit_w & prio_w));
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= rst_s;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign axi_rsp = '{awready: q.awready, wready: q.wready, bvalid: q.bvalid,
		bresp: q.bresp, arready: q.arready, rvalid: q.rvalid, rdata: q.rdata,
		rresp: q.rresp};
	assign chk_hit = q.hit;
	assign chk_any = q.any;
	assign chk_prio = q.prio;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Writable base bits must end up equal to the bus data, not to the merge result
	property p_base_write;
		wr_commit && wr_reg && d.w_strb == 4'hf
			|=> ((q.regs[$past(wr_idx)] ^ $past(d.w_data)) & ~RO_MASK[$past(wr_idx)]
				& 32'hffff_fc00) == 32'h0;
	endproperty
	a_base_write: assert property (p_base_write) else $error("base not stored");

	property p_prio_level;
		chk_valid |=> chk_prio == $past(|(hit_w & prio_w)) && chk_any == $past(|hit_w);
	endproperty
	a_prio_level: assert property (p_prio_level) else $error("priority wrong");

	property p_size_last;
		chk_valid && present_w[0] && end_w[0] <= 42'h100000000
			&& {10'h000, chk_addr} == end_w[0] - 42'h1 |=> chk_hit[0];
	endproperty
	a_size_last: assert property (p_size_last) else $error("last byte missed");

	property p_absent;
		chk_valid && !present_w[0] |=> !chk_hit[0];
	endproperty
	a_absent: assert property (p_absent) else $error("absent region hit");

	property p_zero_bits;
		$rose(q.rvalid) && $past(rd_region) |-> (q.rdata & ~BTR_IMPL_MASK) == 32'h0;
	endproperty
	a_zero_bits: assert property (p_zero_bits) else $error("unused bits set");

	property p_preset;
		&ro_ok_w;
	endproperty
	a_preset: assert property (p_preset) else $error("preset bit changed");

	property p_window;
		chk_valid && present_w[0] && {10'h000, chk_addr} == end_w[0] |=> !chk_hit[0];
	endproperty
	a_window: assert property (p_window) else $error("end address hit");

	property p_base_hit;
		chk_valid && present_w[0] && {10'h000, chk_addr} == base_w[0] |=> chk_hit[0];
	endproperty
	a_base_hit: assert property (p_base_hit) else $error("base address missed");

	// The answer follows the commit at once and blocks further writes meanwhile
	property p_bresp_time;
		wr_commit |=> q.bvalid && !q.awready && !q.wready;
	endproperty
	a_bresp_time: assert property (p_bresp_time) else $error("write answer late");

	c_write: cover property (wr_commit && wr_reg ##1 q.bvalid);
	c_read: cover property ($rose(q.rvalid) && q.rresp == BTR_RESP_OKAY);
	c_hit_prio: cover property (q.any && q.prio);
	c_hit_low: cover property (q.any && !q.prio);

endmodule : btr_region_window

// >>> verif/btr_initiator.sv
// Bus initiator model that offers addresses to the region check port.
// Assumes the bench asks for one check by raising go for one cycle.
module btr_initiator (
	// Clock and request
	input wire logic aclk,
	input wire logic go,
	input wire logic [31:0] addr_in,
	// Check port
	output logic chk_valid = 1'b0,
	output logic [31:0] chk_addr = 32'h0000_0000
);
	timeunit 1ns;
	timeprecision 1ns;

	// One-cycle strobe; the address flips when idle so stale values never match
	always @(posedge aclk) begin
		chk_valid <= go;
		chk_addr <= go ? addr_in : ~chk_addr;
	end
endmodule : btr_initiator

// >>> verif/bus_target_region_window_tb.sv
// Self-checking bench for the region window block.
// Assumes the region map at 4*n and SLVERR for unmapped addresses.
module bus_target_region_window_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import btr_pkg::*;

	// ----------------------------------------------------------------
	// Signals and design
	// ----------------------------------------------------------------
	localparam logic [7:0][31:0] RO = {32'hffff_fc00, 224'h0};
	localparam logic [7:0][31:0] PRE = {32'h1234_5400, 224'h0};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic go = 1'b0;
	logic [31:0] addr_in = 32'h0000_0000;
	logic chk_valid;
	logic [31:0] chk_addr;
	logic [7:0] chk_hit;
	logic chk_any;
	logic chk_prio;
	btr_axi_req_t req = '0;
	btr_axi_rsp_t rsp;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;

	btr_region_window #(.NREG(8), .RO_MASK(RO), .PRESET(PRE)) DUT (.aclk(aclk),
		.aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .chk_valid(chk_valid),
		.chk_addr(chk_addr), .chk_hit(chk_hit), .chk_any(chk_any), .chk_prio(chk_prio));
	btr_initiator u_init (.aclk(aclk), .go(go), .addr_in(addr_in),
		.chk_valid(chk_valid), .chk_addr(chk_addr));

	// 25 MHz clock and a cycle watchdog against hangs
	always #20 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish

	// Write with both channels offered together, held until each is taken
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		req.bready <= 1'b0;
		chk(rsp.bresp, er);
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		req.rready <= 1'b0;
		chk(rsp.rdata, ed);
		chk(rsp.rresp, er);
	endtask : rd

	// One check strobe; the answer stands for exactly one cycle
	task automatic probe(input logic [31:0] a, input logic [9:0] e);
		@(posedge aclk);
		go <= 1'b1;
		addr_in <= a;
		@(posedge aclk);
		go <= 1'b0;
		@(posedge aclk);
		#1;
		chk({chk_any, chk_prio, chk_hit}, e);
		@(posedge aclk);
		#1;
		chk({chk_any, chk_prio, chk_hit}, 10'h0);
	endtask : probe

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic regs_scn();
		rd(32'h0000_0000, 32'h0, BTR_RESP_OKAY);
		rd(32'h0000_001c, 32'h1234_5400, BTR_RESP_OKAY);
		wr(32'h0000_0004, 32'hffff_ffff, BTR_RESP_OKAY);
		rd(32'h0000_0004, 32'hffff_fef8, BTR_RESP_OKAY);
		wr(32'h0000_001c, 32'hffff_ffff, BTR_RESP_OKAY);
		rd(32'h0000_001c, 32'h1234_56f8, BTR_RESP_OKAY);
		wr(32'h0000_001c, 32'h0, BTR_RESP_OKAY);
		rd(32'h0000_001c, 32'h1234_5400, BTR_RESP_OKAY);
		wr(32'h0000_0080, 32'hffff_ffff, BTR_RESP_SLVERR);
		rd(32'h0000_0080, 32'h0, BTR_RESP_SLVERR);
		// Status is read-only: the write is dropped, only region 1 is present now
		wr(BTR_STATUS_OFF, 32'hffff_ffff, BTR_RESP_OKAY);
		rd(BTR_STATUS_OFF, 32'h0000_0002, BTR_RESP_OKAY);
	endtask : regs_scn

	task automatic window_scn();
		wr(32'h0000_0000, 32'h0001_0008, BTR_RESP_OKAY);
		wr(32'h0000_0008, 32'h0004_0218, BTR_RESP_OKAY);
		probe(32'h0001_0000, 10'h201);
		probe(32'h0001_03ff, 10'h201);
		probe(32'h0001_0400, 10'h000);
		probe(32'h0000_ffff, 10'h000);
		probe(32'h0004_0fff, 10'h304);
		probe(32'h0004_1000, 10'h000);
		probe(32'hffff_fffc, 10'h302);
		wr(32'h0000_0004, 32'hffff_fc00, BTR_RESP_OKAY);
		probe(32'hffff_fffc, 10'h000);
	endtask : window_scn

	// Reset for 4 cycles, then the scenarios in turn
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		regs_scn();
		window_scn();
		tally_and_finish();
	end
endmodule : bus_target_region_window_tb
